// [hw/sasp_pkg.sv]
// Purpose: Shared constants and types of the serial audio output port.
// Assumes: APB register map with 32-bit data and one word per register.
// Notes: Bit positions count half-frame slots of 32 bit clocks each.
package sasp_pkg;
    // Register map, byte addresses.
    localparam int ADDR_W = 12;
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STAT_OFS = 12'h004;
    // Control register fields.
    localparam int CTRL_W = 6;
    localparam int CTRL_PDN_BIT = 0;
    localparam int CTRL_FMT_LSB = 1;
    localparam int CTRL_IF_LSB = 3;
    localparam int CTRL_OSR_BIT = 5;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    // Status register fields.
    localparam int STAT_LOCK_BIT = 0;
    localparam int STAT_RATIO_LSB = 1;
    localparam int STAT_RATIO_OK_BIT = 3;
    localparam int STAT_B48_BIT = 4;
    localparam int STAT_MASTER_BIT = 5;
    localparam int WORD_W = 24;
    typedef enum logic [1:0] {
        FMT_LJ24 = 2'b00, FMT_I2S24 = 2'b01,
        FMT_RJ24 = 2'b10, FMT_RJ20 = 2'b11
    } sasp_fmt_t;
    typedef enum logic [1:0] {
        IF_SLAVE = 2'b00, IF_M512 = 2'b01,
        IF_M384 = 2'b10, IF_M256 = 2'b11
    } sasp_if_t;
    typedef enum logic [1:0] {
        RATIO_256 = 2'b00, RATIO_384 = 2'b01,
        RATIO_512 = 2'b10, RATIO_768 = 2'b11
    } sasp_ratio_t;
    // Word start slot and length inside a half frame.
    localparam logic [4:0] OFS_LJ = 5'h00;
    localparam logic [4:0] OFS_I2S = 5'h01;
    localparam logic [4:0] OFS_RJ24 = 5'h08;
    localparam logic [4:0] OFS_RJ20 = 5'h0c;
    localparam logic [4:0] LEN_24 = 5'h18;
    localparam logic [4:0] LEN_20 = 5'h14;
    // Bit clocks per short frame in slave mode; any other count is taken as 64.
    localparam logic [6:0] BITS48 = 7'h30;
    // Drift limits in bit clocks: loss above LOSE, lock regained at or below HOLD.
    localparam logic [2:0] LOSE64 = 3'h6;
    localparam logic [2:0] LOSE48 = 3'h5;
    localparam logic [2:0] HOLD64 = 3'h5;
    localparam logic [2:0] HOLD48 = 3'h4;
    // Master bit clock half periods in pclk cycles (ratio / 128).
    localparam logic [2:0] HALF_M256 = 3'h2;
    localparam logic [2:0] HALF_M384 = 3'h3;
    localparam logic [2:0] HALF_M512 = 3'h4;
    // Nominal pclk counts per frame and detection tolerance.
    localparam logic [11:0] NOM_256 = 12'h100;
    localparam logic [11:0] NOM_384 = 12'h180;
    localparam logic [11:0] NOM_512 = 12'h200;
    localparam logic [11:0] NOM_768 = 12'h300;
    localparam logic [11:0] NOM_TOL = 12'h010;
endpackage : sasp_pkg

// [hw/sasp_port.sv]
// Purpose: Serial audio output port, master or slave, with APB control.
// Assumes: pclk is the system clock; samples arrive on pclk with a strobe.
// Notes: Slave pins are sampled by pclk, so bit clocks are far slower.
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/10ps
module sasp_port
    import sasp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sasp_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [sasp_pkg::WORD_W-1:0] sample_left,
    input wire logic [sasp_pkg::WORD_W-1:0] sample_right,
    input wire logic sample_valid,
    input wire logic bit_clock_in,
    output logic bit_clock_out,
    output logic bit_clock_oe,
    input wire logic frame_clock_in,
    output logic frame_clock_out,
    output logic frame_clock_oe,
    input wire logic data_valid_frame_in,
    output logic data_valid_frame_out,
    output logic data_valid_frame_oe,
    output logic serial_data,
    output logic serial_data_oe,
    output logic modulator_osr128
);
    import sasp_pkg::*;

    // Word start slot of each format.
    function automatic logic [4:0] fmt_ofs(input logic [1:0] f);
        case (f)
            FMT_LJ24: fmt_ofs = OFS_LJ;
            FMT_I2S24: fmt_ofs = OFS_I2S;
            FMT_RJ24: fmt_ofs = OFS_RJ24;
            default: fmt_ofs = OFS_RJ20;
        endcase
    endfunction : fmt_ofs

    // True while slot p of a half frame carries a data bit.
    function automatic logic in_win(input logic [4:0] p, input logic [1:0] f);
        logic [4:0] d;
        d = p - fmt_ofs(f);
        in_win = d < ((f == FMT_RJ20) ? LEN_20 : LEN_24);
    endfunction : in_win

    // Drift exceeds t bit clocks when delta * bits > ref * t.
    function automatic logic drift_over(input logic [11:0] dl,
        input logic [11:0] rf, input logic b48, input logic [2:0] t);
        logic [19:0] lhs;
        logic [19:0] rhs;
        lhs = 20'(dl) * (b48 ? 20'h30 : 20'h40);
        rhs = 20'(rf) * 20'(t);
        drift_over = lhs > rhs;
    endfunction : drift_over

    // Nearest nominal ratio; the top bit is low when none fits.
    function automatic logic [2:0] ratio_class(input logic [11:0] m);
        ratio_class = 3'h0;
        if (m >= NOM_256 - NOM_TOL && m <= NOM_256 + NOM_TOL) begin
            ratio_class = {1'b1, RATIO_256};
        end else if (m >= NOM_384 - NOM_TOL && m <= NOM_384 + NOM_TOL) begin
            ratio_class = {1'b1, RATIO_384};
        end else if (m >= NOM_512 - NOM_TOL && m <= NOM_512 + NOM_TOL) begin
            ratio_class = {1'b1, RATIO_512};
        end else if (m >= NOM_768 - NOM_TOL && m <= NOM_768 + NOM_TOL) begin
            ratio_class = {1'b1, RATIO_768};
        end
    endfunction : ratio_class

    logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
    logic [31:0] prdata_next;
    logic pready_next, pslverr_next, acc;
    logic [2:0] pin_s;
    logic pdn, master;
    logic [1:0] fmt, ifc;
    logic [2:0] half;

    assign pdn = ctrl_reg[CTRL_PDN_BIT];
    assign fmt = ctrl_reg[CTRL_FMT_LSB +: 2];
    assign ifc = ctrl_reg[CTRL_IF_LSB +: 2];
    assign master = ifc != IF_SLAVE;
    // Only three master ratios decode; 768 fs has no code here.
    assign half = (ifc == IF_M256) ? HALF_M256 :
                  (ifc == IF_M384) ? HALF_M384 : HALF_M512;

    // Link pins cross into pclk before any logic reads them.
    sasp_sync #(.WIDTH(3)) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({data_valid_frame_in, frame_clock_in, bit_clock_in}),
        .q(pin_s)
    );

    // Status word built from live state.
    logic locked_reg, bits48_reg, ratio_ok_reg;
    logic [1:0] ratio_reg;
    logic [31:0] stat_word;
    assign stat_word = {26'h0, master, bits48_reg, ratio_ok_reg, ratio_reg,
                        locked_reg};

    // APB slave: pready rises in the access phase, one wait-free answer.
    always_comb begin
        acc = psel && penable && pready;
        ctrl_next = ctrl_reg;
        pready_next = psel && !penable;
        prdata_next = 32'h0;
        pslverr_next = 1'b0;
        if (psel && !penable) begin
            if (paddr == CTRL_OFS) begin
                prdata_next = {26'h0, ctrl_reg};
            end else if (paddr == STAT_OFS) begin
                prdata_next = stat_word;
            end else begin
                pslverr_next = 1'b1;
            end
        end
        if (acc && pwrite && paddr == CTRL_OFS) begin
            ctrl_next = pwdata[CTRL_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RESET;
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            pready <= pready_next;
            prdata <= prdata_next;
            pslverr <= pslverr_next;
        end
    end

    // Link group state.
    logic [2:0] div_reg, div_next;
    logic [5:0] pos_reg, pos_next;
    logic bck_d_reg, bck_d_next, fr_smp_reg, fr_smp_next;
    logic dvf_smp_reg, dvf_smp_next;
    logic [WORD_W-1:0] sreg_reg, sreg_next, hold_l_reg, hold_r_reg;
    logic [WORD_W-1:0] hold_l_next, hold_r_next, src;
    logic [6:0] bcnt_reg, bcnt_next;
    logic bck_o_next, fr_o_next, dvf_o_next, dout_next, oe_next;
    logic osr_next, bits48_next;
    logic m_tick, m_fall, s_rise, s_fall, s_fedge, s_frise, left;

    // Edge events: master from the divider, slave from synced pins.
    assign m_tick = pdn && master && div_reg == half - 3'h1;
    assign m_fall = m_tick && bit_clock_out;
    assign s_rise = pdn && !master && pin_s[0] && !bck_d_reg;
    assign s_fall = pdn && !master && !pin_s[0] && bck_d_reg;
    assign s_fedge = s_rise && pin_s[1] != fr_smp_reg;
    assign s_frise = s_rise && pin_s[1] && !fr_smp_reg;
    // I2S puts left in the low frame clock phase.
    assign left = (fmt == FMT_I2S24) ? !pin_s[1] : pin_s[1];

    always_comb begin
        div_next = div_reg;
        pos_next = pos_reg;
        bck_d_next = pin_s[0];
        fr_smp_next = fr_smp_reg;
        dvf_smp_next = dvf_smp_reg;
        sreg_next = sreg_reg;
        bcnt_next = bcnt_reg;
        bits48_next = bits48_reg;
        bck_o_next = bit_clock_out;
        fr_o_next = frame_clock_out;
        dvf_o_next = data_valid_frame_out;
        dout_next = serial_data;
        oe_next = pdn && master;
        osr_next = ctrl_reg[CTRL_OSR_BIT];
        hold_l_next = sample_valid ? sample_left : hold_l_reg;
        hold_r_next = sample_valid ? sample_right : hold_r_reg;
        src = sreg_reg;
        if (!pdn) begin
            // Everything idles and the data pin is released.
            div_next = 3'h0;
            pos_next = 6'h3f;
            bck_o_next = 1'b0;
            fr_o_next = 1'b0;
            dvf_o_next = 1'b0;
            dout_next = 1'b0;
            sreg_next = '0;
        end else if (master) begin
            // Divide pclk down to 64 bit clocks per frame.
            div_next = m_tick ? 3'h0 : div_reg + 3'h1;
            if (m_tick) begin
                bck_o_next = !bit_clock_out;
            end
            if (m_fall) begin
                // Frame clock, valid frame and data all move on the bit clock fall.
                pos_next = pos_reg + 6'h01;
                fr_o_next = (fmt == FMT_I2S24) ? pos_next[5] : !pos_next[5];
                dvf_o_next = in_win(pos_next[4:0], fmt);
                if (pos_next[4:0] == 5'h00) begin
                    src = pos_next[5] ? hold_r_reg : hold_l_reg;
                end
                // MSB first; zero code while unlocked.
                dout_next = in_win(pos_next[4:0], fmt) && src[WORD_W-1] &&
                            locked_reg;
                sreg_next = in_win(pos_next[4:0], fmt) ?
                            {src[WORD_W-2:0], 1'b0} : src;
            end
        end else begin
            if (s_rise) begin
                // Frame clock and valid frame sampled on the rise.
                fr_smp_next = pin_s[1];
                dvf_smp_next = pin_s[2];
                bcnt_next = s_frise ? 7'h01 : bcnt_reg + 7'h01;
                if (s_frise) begin
                    bits48_next = bcnt_reg == BITS48;
                end
            end
            if (s_fedge) begin
                sreg_next = left ? hold_l_reg : hold_r_reg;
                dout_next = 1'b0;
            end else if (s_fall) begin
                // Shift only inside the external valid frame.
                dout_next = dvf_smp_reg && sreg_reg[WORD_W-1] && locked_reg;
                if (dvf_smp_reg) begin
                    sreg_next = {sreg_reg[WORD_W-2:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 3'h0;
            pos_reg <= 6'h3f;
            bck_d_reg <= 1'b0;
            fr_smp_reg <= 1'b0;
            dvf_smp_reg <= 1'b0;
            sreg_reg <= '0;
            hold_l_reg <= '0;
            hold_r_reg <= '0;
            bcnt_reg <= 7'h00;
            bits48_reg <= 1'b0;
            bit_clock_out <= 1'b0;
            frame_clock_out <= 1'b0;
            data_valid_frame_out <= 1'b0;
            serial_data <= 1'b0;
            serial_data_oe <= 1'b0;
            bit_clock_oe <= 1'b0;
            frame_clock_oe <= 1'b0;
            data_valid_frame_oe <= 1'b0;
            modulator_osr128 <= 1'b0;
        end else begin
            div_reg <= div_next;
            pos_reg <= pos_next;
            bck_d_reg <= bck_d_next;
            fr_smp_reg <= fr_smp_next;
            dvf_smp_reg <= dvf_smp_next;
            sreg_reg <= sreg_next;
            hold_l_reg <= hold_l_next;
            hold_r_reg <= hold_r_next;
            bcnt_reg <= bcnt_next;
            bits48_reg <= bits48_next;
            bit_clock_out <= bck_o_next;
            frame_clock_out <= fr_o_next;
            data_valid_frame_out <= dvf_o_next;
            serial_data <= dout_next;
            serial_data_oe <= pdn;
            bit_clock_oe <= oe_next;
            frame_clock_oe <= oe_next;
            data_valid_frame_oe <= oe_next;
            modulator_osr128 <= osr_next;
        end
    end

    // Sync monitor: frame length in pclk against the previous frame's length.
    // A stopped frame clock saturates the counter and drops the lock.
    logic [11:0] fcnt_reg, fcnt_next, ref_reg, ref_next, meas, delta;
    logic locked_next, ratio_ok_next, lose, keep;
    logic [1:0] ratio_next;
    logic [2:0] cls;

    always_comb begin
        meas = fcnt_reg + 12'h001;
        delta = (meas > ref_reg) ? meas - ref_reg : ref_reg - meas;
        lose = drift_over(delta, ref_reg, bits48_reg,
                          bits48_reg ? LOSE48 : LOSE64);
        keep = !drift_over(delta, ref_reg, bits48_reg,
                           bits48_reg ? HOLD48 : HOLD64);
        cls = ratio_class(meas);
        fcnt_next = (fcnt_reg == 12'hfff) ? fcnt_reg : meas;
        ref_next = ref_reg;
        locked_next = locked_reg;
        ratio_next = ratio_reg;
        ratio_ok_next = ratio_ok_reg;
        if (!pdn || master) begin
            fcnt_next = 12'h000;
            locked_next = pdn;
            ratio_ok_next = 1'b0;
        end else if (s_frise) begin
            fcnt_next = 12'h000;
            ref_next = meas;
            ratio_next = cls[1:0];
            ratio_ok_next = cls[2];
            if (locked_reg) begin
                locked_next = !lose;
            end else begin
                locked_next = keep;
            end
        end else if (fcnt_reg == 12'hfff) begin
            locked_next = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fcnt_reg <= 12'h000;
            ref_reg <= 12'h000;
            locked_reg <= 1'b0;
            ratio_reg <= 2'b00;
            ratio_ok_reg <= 1'b0;
        end else begin
            fcnt_reg <= fcnt_next;
            ref_reg <= ref_next;
            locked_reg <= locked_next;
            ratio_reg <= ratio_next;
            ratio_ok_reg <= ratio_ok_next;
        end
    end

    property p_apb_ready;
        @(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("pready late");
    property p_pdn;
        @(posedge pclk) disable iff (!presetn)
        !pdn |=> !serial_data_oe && !serial_data && !bit_clock_oe;
    endproperty
    a_pdn: assert property (p_pdn) else $error("power down leak");
    property p_master_oe;
        @(posedge pclk) disable iff (!presetn)
        pdn && master |=> frame_clock_oe && data_valid_frame_oe;
    endproperty
    a_master_oe: assert property (p_master_oe) else $error("oe off");
    property p_bck_256;
        @(posedge pclk) disable iff (!presetn)
        $rose(bit_clock_out) && ifc == IF_M256 && $stable(ctrl_reg)
        |=> bit_clock_out ##1 !bit_clock_out;
    endproperty
    a_bck_256: assert property (p_bck_256) else $error("bck ratio");
    property p_fr_on_fall;
        @(posedge pclk) disable iff (!presetn)
        pdn && master && $changed(frame_clock_out) |-> $fell(bit_clock_out);
    endproperty
    a_fr_on_fall: assert property (p_fr_on_fall) else $error("fr");
    property p_fr_period;
        @(posedge pclk) disable iff (!presetn)
        m_fall && pos_reg[4:0] != 5'h1f |=> $stable(frame_clock_out);
    endproperty
    a_fr_period: assert property (p_fr_period) else $error("frame len");
    property p_dvf_start;
        @(posedge pclk) disable iff (!presetn)
        pdn && master && $rose(data_valid_frame_out)
        |-> pos_reg[4:0] == fmt_ofs(fmt);
    endproperty
    a_dvf_start: assert property (p_dvf_start) else $error("dvf st");
    property p_dvf_end;
        @(posedge pclk) disable iff (!presetn)
        pdn && master && $fell(data_valid_frame_out) && $stable(ctrl_reg)
        |-> pos_reg[4:0] == fmt_ofs(fmt) +
            ((fmt == FMT_RJ20) ? LEN_20 : LEN_24);
    endproperty
    a_dvf_end: assert property (p_dvf_end) else $error("dvf length");
    property p_slave_idle;
        @(posedge pclk) disable iff (!presetn)
        s_fall && !s_fedge && !dvf_smp_reg |=> !serial_data;
    endproperty
    a_slave_idle: assert property (p_slave_idle) else $error("shift");
    property p_lose;
        @(posedge pclk) disable iff (!presetn)
        s_frise && locked_reg && lose |=> !locked_reg ##1 !serial_data;
    endproperty
    a_lose: assert property (p_lose) else $error("no halt");
    property p_keep;
        @(posedge pclk) disable iff (!presetn)
        s_frise && locked_reg && keep && !master |=> locked_reg;
    endproperty
    a_keep: assert property (p_keep) else $error("false resync");
    c_master_frame: cover property (@(posedge pclk) disable iff (!presetn)
        m_fall && pos_reg == 6'h3f);
    c_slave_lock: cover property (@(posedge pclk) disable iff (!presetn)
        !master && $rose(locked_reg));
    c_slave_loss: cover property (@(posedge pclk) disable iff (!presetn)
        pdn && !master && $fell(locked_reg));
endmodule : sasp_port

// [hw/sasp_sync.sv]
// Purpose: Two-flop synchroniser for pins from outside the pclk domain.
// Assumes: Inputs are slow levels compared with pclk.
// Notes: Only the second stage is visible to the rest of the design.
`timescale 1ns/10ps
module sasp_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    // First stage feeds the second stage and nothing else.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : sasp_sync

// [verification/sasp_ctrl_model.sv]
// Purpose: Slave-mode timing controller that drives the port's link pins.
// Assumes: 125 ns bit clock; the left half comes first, frame clock high.
// Notes: The bit clock stands still between frames, when run is low.
`timescale 1ns/10ps
module sasp_ctrl_model (
    input wire logic run,
    input wire logic [6:0] bits,
    input wire logic [3:0] extra,
    output logic bit_clock,
    output logic frame_clock,
    output logic dvf
);
    int n;
    int h;
    int j;
    // Idle levels before the first frame, so the port never sees unknowns.
    initial begin
        bit_clock = 1'b1;
        frame_clock = 1'b0;
        dvf = 1'b0;
    end
    // Pins move on the fall, half a period away from the sampling rise.
    always begin
        wait (run);
        n = bits + extra; // Extra bits stretch one frame.
        h = n - bits / 2;
        for (int i = 0; i < n; i++) begin
            #62.5 bit_clock = 1'b0;
            j = (i < h) ? i : i - h;
            frame_clock = (i < h);
            dvf = (j >= 1) && (j <= 24) && (j < bits / 2);
            #62.5 bit_clock = 1'b1;
        end
    end
endmodule : sasp_ctrl_model

// [verification/test_stereo_adc_serial_audio_port.sv]
// Purpose: Self-checking bench of the port in master and slave modes.
// Assumes: Zero-wait APB; slave pins come from the controller model.
// Notes: Outputs are read right after an edge, before it updates them.
`timescale 1ns/10ps
module test_stereo_adc_serial_audio_port;
    import sasp_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h68e9;
    logic pready, pslverr, er, bco, bcoe, fco, fcoe, dvo, dvoe, sd, sdoe, oversample_sel;
    logic [23:0] sl = 24'h0, sr = 24'h0, sw, acc = 24'h0;
    logic sv = 1'b0, run = 1'b0, bit_clock, frame_clock, dvf, dvp = 1'b0, lrp = 1'b0;
    logic [6:0] bits = 7'h40;
    logic [3:0] extra = 4'h0;
    int fails = 0;
    int n_checks = 0;
    int cnt = 0;
    always #2 pclk = ~pclk;
    sasp_port uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_left(sl), .sample_right(sr), .sample_valid(sv),
        .bit_clock_in(bit_clock), .bit_clock_out(bco), .bit_clock_oe(bcoe),
        .frame_clock_in(frame_clock), .frame_clock_out(fco), .frame_clock_oe(fcoe),
        .data_valid_frame_in(dvf), .data_valid_frame_out(dvo),
        .data_valid_frame_oe(dvoe), .serial_data(sd),
        .serial_data_oe(sdoe), .modulator_osr128(oversample_sel));
    sasp_ctrl_model partner (.run(run), .bits(bits), .extra(extra),
        .bit_clock(bit_clock), .frame_clock(frame_clock), .dvf(dvf));
    // Slave data: one bit after each rise that sampled valid high, left only.
    always @(posedge bit_clock) begin
        if (frame_clock && !lrp) cnt = 0;
        if (dvp && cnt < 24) begin
            acc = {acc[22:0], sd};
            cnt++;
            if (cnt == 24) sw = acc;
        end
        dvp = dvf && frame_clock;
        lrp = frame_clock;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h000000c5 : 32'h0);
    endfunction : lfsr
    function automatic logic [31:0] wexp(input logic [23:0] s,
        input logic [1:0] f);
        return (f == 2'b11) ? {12'h0, s[23:4]} : {8'h0, s};
    endfunction : wexp
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 16);
        if (k >= 16) begin fails++; stop_test(); end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task wait_lr(input int n);
        int c;
        logic p;
        c = 0;
        p = frame_clock;
        for (int k = 0; k < 6000 * n && c < n; k++) begin
            @(posedge pclk);
            if (frame_clock && !p) c++;
            p = frame_clock;
        end
        if (c < n) begin fails++; stop_test(); end
    endtask : wait_lr
    task wait_lock(input logic v);
        int k;
        k = 0;
        do begin
            apb(1'b0, STAT_OFS, 32'h0);
            repeat (50) @(posedge pclk);
            k++;
        end while (rd[0] !== v && k < 400);
        chk("lock", v, rd[0]);
    endtask : wait_lock
    task bit_rise(inout int cyc);
        int k;
        logic p;
        k = 0;
        do begin p = bco; @(posedge pclk); k++; end
        while (!(bco === 1'b1 && p === 1'b0) && k < 64);
        cyc += k;
    endtask : bit_rise
    task master_run(input logic [1:0] m, input logic [1:0] f);
        logic [23:0] w[2];
        int nb[2];
        int cyc;
        int k;
        logic lv;
        seed = lfsr(seed);
        sl <= seed[23:0];
        sr <= ~seed[23:0];
        sv <= 1'b1;
        @(posedge pclk);
        sv <= 1'b0;
        apb(1'b1, CTRL_OFS, 32'h0); // Power down first to reconfigure.
        apb(1'b1, CTRL_OFS, {26'h0, seed[31], m, f, 1'b1});
        repeat (2) @(posedge pclk);
        chk("osr128", seed[31], oversample_sel);
        chk("oe", 3'b111, {bcoe, fcoe, dvoe});
        lv = (f != 2'b01);
        k = 0;
        while (fco !== !lv && k < 3000) begin @(posedge pclk); k++; end
        while (fco !== lv && k < 3000) begin @(posedge pclk); k++; end
        chk("sync", 1, k < 3000);
        cyc = 0;
        nb = '{0, 0};
        w = '{24'h0, 24'h0};
        for (int i = 0; i < 64; i++) begin
            bit_rise(cyc);
            if (i == 0) cyc = 0;
            chk("frame", (i < 32) ? lv : !lv, fco);
            if (dvo) begin w[i / 32] = {w[i / 32][22:0], sd}; nb[i / 32]++; end
        end
        chk("period", 126 * (5 - m), cyc);
        chk("len_l", (f == 2'b11) ? 20 : 24, nb[0]);
        chk("len_r", (f == 2'b11) ? 20 : 24, nb[1]);
        chk("left", wexp(sl, f), w[0]);
        chk("right", wexp(sr, f), w[1]);
    endtask : master_run
    // Bounded run time; running out counts as a mismatch.
    initial begin
        #400000;
        fails++;
        stop_test();
    end
    // Main sequence: registers, every master mode and format, then slave.
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl_rst", CTRL_RESET, rd);
        chk("pins_rst", 3'b000, {bcoe, sdoe, sd});
        apb(1'b0, 12'h008, 32'h0);
        chk("unmapped_err", 1, er);
        chk("unmapped_rd", 0, rd);
        seed = lfsr(seed);
        apb(1'b1, CTRL_OFS, seed & 32'hfffffffe);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl_rw", seed[5:0] & 6'h3e, rd);
        @(posedge pclk);
        chk("osr", seed[5], oversample_sel);
        for (int m = 1; m < 4; m++)
            for (int f = 0; f < 4; f++) master_run(m[1:0], f[1:0]);
        apb(1'b1, CTRL_OFS, 32'h0);
        apb(1'b1, CTRL_OFS, 32'h1);
        run <= 1'b1;
        wait_lock(1'b1);
        chk("slave", 4'h1, {rd[5], rd[4], bcoe, rd[0]});
        wait_lr(2);
        chk("s_word", sl, sw);
        extra <= 4'h4;
        wait_lr(1);
        extra <= 4'h0;
        wait_lr(2);
        apb(1'b0, STAT_OFS, 32'h0);
        chk("keep", 1, rd[0]);
        extra <= 4'h8;
        wait_lr(1);
        extra <= 4'h0;
        wait_lr(2);
        apb(1'b0, STAT_OFS, 32'h0);
        chk("lost", 0, rd[0]);
        chk("zero", 0, sw);
        wait_lock(1'b1);
        bits <= 7'h30;
        wait_lr(3);
        wait_lock(1'b1);
        chk("b48", 1, rd[4]);
        run <= 1'b0;
        apb(1'b1, CTRL_OFS, 32'h0);
        @(posedge pclk);
        chk("pdn", 2'b00, {sd, sdoe});
        stop_test();
    end
endmodule : test_stereo_adc_serial_audio_port
